// ===== hw/cst_pkg.sv
// Shared constants and types for the charge status and timer control block
package cst_pkg;

  // Avalon-MM register map, byte addresses of 32-bit words
  localparam logic [3:0] CST_REG_CTRL = 4'h0;
  localparam logic [3:0] CST_REG_STATUS = 4'h4;
  localparam logic [3:0] CST_REG_TMR_LIMIT = 4'h8;
  localparam logic [3:0] CST_REG_TMR_COUNT = 4'hc;

  // Control register field positions
  localparam int CST_CTRL_TMR_OPEN_BIT = 0;
  localparam int CST_CTRL_STOP_ALLOW_N_BIT = 1;
  localparam int CST_CTRL_TERM_DONE_BIT = 2;
  localparam logic [2:0] CST_CTRL_RESET = 3'h0;

  // Precharge timeout is a factor times the programmed fast-charge timeout
  localparam logic [31:0] CST_FAST_TIMEOUT_TICKS_RESET = 32'h0000_1000;
  localparam int CST_PRECHG_FACTOR_SHIFT = 3;

  // Thermal foldback: current step range, floor about one fifth of full scale
  localparam logic [7:0] CST_CUR_FULL = 8'hff;
  localparam logic [7:0] CST_CUR_FLOOR = 8'h33;
  localparam logic [7:0] CST_CUR_STEP = 8'h01;

  // Divider for the timer tick
  localparam logic [7:0] CST_TICK_DIV = 8'h7c;

  // Comparator inputs travel together
  typedef struct packed {
    logic in_present;
    logic in_overvolt;
    logic temp_ok;
    logic above_prechg;
    logic at_reg;
    logic tj_over_reg;
    logic tj_shutdown;
    logic stop_allow_n;
  } cst_cmp_s;

  // Operating modes
  typedef enum logic [2:0] {
    CST_SLEEP,
    CST_STANDBY,
    CST_CHARGING,
    CST_SUSPEND,
    CST_FAULT
  } cst_mode_e;

  // Charge phases
  typedef enum logic [1:0] {
    CST_PH_PRECHG,
    CST_PH_FAST,
    CST_PH_CV
  } cst_phase_e;

endpackage : cst_pkg

// ===== hw/cst_sync.sv
// Two-flop synchroniser for a bundle of comparator levels
`timescale 1ns/1ps
module cst_sync (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire cst_pkg::cst_cmp_s i_async,
  output cst_pkg::cst_cmp_s o_sync
);
  import cst_pkg::*;

  cst_cmp_s meta_ff;
  cst_cmp_s sync_ff;

  // First stage feeds only the second stage
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;
endmodule : cst_sync

// ===== hw/cst_top.sv
// Charge control: modes, status pins, precharge timer, fault latch, thermal loop
//
// Register access over Avalon-MM and the address map were left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// - Pack temperature out: stage off, timers freeze
// - Temperature back in window: resume from held counts
// - Power-good low only with input, no overvoltage
// - Overvoltage switches charger off into standby
// - Overvoltage not latched, recovers at once
// - Status pins encode precharge, fast, done, off
// - Termination disabled: never done, show phase
// - Fast current above threshold, tenth below
// - Regulation voltage reached: constant-voltage phase
// - Precharge timeout is factor times fast timeout
// - Precharge timer reset, hold, count per mode
// - Precharge timeout below threshold: off, fault latched
// - Fault latched: recovery current with input, low
// - Fault cleared by enable rise, overvoltage, input loss, timer off
// - Thermal loop folds current to floor
// - Continued heating enters thermal shutdown suspend
// - No input: sleep, stage off, pins released
// - Enable low charges, high gives standby
// - Standby resets timers, suspend holds them
module cst_top (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_charge_enable_n,
  input wire cst_pkg::cst_cmp_s i_cmp,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_power_stage_on,
  output logic o_fast_current_sel,
  output logic o_prechg_current_sel,
  output logic o_cv_phase,
  output logic o_recovery_trickle_on,
  output logic [7:0] o_current_limit,
  output logic o_status_out_a_pd,
  output logic o_status_out_b_pd,
  output logic o_power_good_n_pd
);
  import cst_pkg::*;

  cst_cmp_s cmp;
  cst_sync u_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_async(i_cmp),
    .o_sync(cmp)
  );

  logic ce_meta_ff;
  logic ce_n_ff;
  logic ce_n_d_ff;
  logic [2:0] ctrl_ff;
  logic [31:0] fast_limit_ff;
  logic [31:0] pre_cnt_ff;
  logic [31:0] nxt_pre_cnt;
  logic [7:0] div_ff;
  logic fault_ff;
  logic nxt_fault;
  logic tshut_ff;
  logic [7:0] cur_ff;
  cst_mode_e mode_ff;
  cst_mode_e nxt_mode;
  cst_phase_e phase_ff;
  logic wait_ff;
  logic [31:0] rdata_ff;
  logic stage_ff;
  logic fast_ff;
  logic pre_ff;
  logic cv_ff;
  logic trickle_ff;
  logic stat_a_ff;
  logic stat_b_ff;
  logic pg_ff;

  // Enable pin is asynchronous to the clock
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      ce_meta_ff <= 1'b1;
      ce_n_ff <= 1'b1;
      ce_n_d_ff <= 1'b1;
    end else begin
      ce_meta_ff <= i_charge_enable_n;
      ce_n_ff <= ce_meta_ff;
      ce_n_d_ff <= ce_n_ff;
    end
  end

  // Decoded conditions
  wire tmr_open = ctrl_ff[CST_CTRL_TMR_OPEN_BIT];
  wire term_disabled = tmr_open | ctrl_ff[CST_CTRL_STOP_ALLOW_N_BIT] | cmp.stop_allow_n;
  wire term_done = ctrl_ff[CST_CTRL_TERM_DONE_BIT] & ~term_disabled;
  wire ce_rise = ce_n_ff & ~ce_n_d_ff;
  wire in_ok = cmp.in_present & ~cmp.in_overvolt;
  wire tick = (div_ff == 8'h00);
  wire suspend_cond = ~cmp.temp_ok | tshut_ff;
  // precharge limit derived from fast limit
  wire [31:0] pre_limit = fast_limit_ff << CST_PRECHG_FACTOR_SHIFT;
  wire pre_expired = (pre_cnt_ff >= pre_limit);
  wire charging = (mode_ff == CST_CHARGING);

  // Timer tick divider
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      div_ff <= CST_TICK_DIV;
    end else begin
      div_ff <= tick ? CST_TICK_DIV : div_ff - 8'h01;
    end
  end

  // Mode selection
  always_comb begin
    nxt_mode = mode_ff;
    if (!cmp.in_present) begin
      nxt_mode = CST_SLEEP;
    end else if (cmp.in_overvolt || ce_n_ff) begin
      nxt_mode = CST_STANDBY;
    end else if (fault_ff || nxt_fault) begin
      nxt_mode = CST_FAULT;
    end else if (suspend_cond) begin
      nxt_mode = CST_SUSPEND;
    end else begin
      nxt_mode = CST_CHARGING;
    end
  end

  // Precharge timer mode
  always_comb begin
    nxt_pre_cnt = pre_cnt_ff;
    if (tmr_open || mode_ff == CST_STANDBY || mode_ff == CST_SLEEP || cmp.above_prechg) begin
      nxt_pre_cnt = 32'h0;
    end else if (charging && tick && !pre_expired) begin
      nxt_pre_cnt = pre_cnt_ff + 32'h1;
    end
  end

  // Fault latch: set wins over clear
  always_comb begin
    nxt_fault = fault_ff;
    if (ce_rise || cmp.in_overvolt || !cmp.in_present || tmr_open) begin
      nxt_fault = 1'b0;
    end
    if (charging && pre_expired && !cmp.above_prechg && !tmr_open) begin
      nxt_fault = 1'b1;
    end
  end

  // State registers
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      mode_ff <= CST_SLEEP;
      pre_cnt_ff <= 32'h0;
      fault_ff <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      pre_cnt_ff <= nxt_pre_cnt;
      fault_ff <= nxt_fault;
    end
  end

  // Charge phase from battery comparators
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      phase_ff <= CST_PH_PRECHG;
    end else if (cmp.at_reg) begin
      phase_ff <= CST_PH_CV;
    end else if (cmp.above_prechg) begin
      phase_ff <= CST_PH_FAST;
    end else begin
      phase_ff <= CST_PH_PRECHG;
    end
  end

  // Thermal foldback steps on the slow tick; shutdown acts every cycle
  // so the stage drops without waiting up to a full tick period
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      cur_ff <= CST_CUR_FULL;
      tshut_ff <= 1'b0;
    end else begin
      // shutdown level, hysteresis is in the comparator
      tshut_ff <= cmp.tj_shutdown;
      if (tick) begin
        if (cmp.tj_over_reg && cur_ff > CST_CUR_FLOOR) begin
          cur_ff <= cur_ff - CST_CUR_STEP;
        end else if (!cmp.tj_over_reg && cur_ff < CST_CUR_FULL) begin
          cur_ff <= cur_ff + CST_CUR_STEP;
        end
      end
    end
  end

  // Status encoding
  wire show_pre = charging && phase_ff == CST_PH_PRECHG;
  wire show_done = charging && term_done;
  wire show_fast = charging && !show_pre && !show_done;

  // Output registers
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      stage_ff <= 1'b0;
      fast_ff <= 1'b0;
      pre_ff <= 1'b0;
      cv_ff <= 1'b0;
      trickle_ff <= 1'b0;
      stat_a_ff <= 1'b0;
      stat_b_ff <= 1'b0;
      pg_ff <= 1'b0;
    end else begin
      stage_ff <= charging && !term_done;
      fast_ff <= charging && phase_ff != CST_PH_PRECHG;
      pre_ff <= charging && phase_ff == CST_PH_PRECHG;
      cv_ff <= charging && phase_ff == CST_PH_CV;
      trickle_ff <= fault_ff && cmp.in_present && !cmp.above_prechg;
      // status code; done hidden when termination off
      stat_a_ff <= show_pre || show_fast;
      stat_b_ff <= show_pre || show_done;
      pg_ff <= in_ok;
    end
  end

  // Avalon-MM slave: one wait cycle, answer on the second edge
  wire bus_req = i_avs_read | i_avs_write;
  wire bus_take = bus_req & wait_ff;
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      wait_ff <= 1'b1;
      ctrl_ff <= CST_CTRL_RESET;
      fast_limit_ff <= CST_FAST_TIMEOUT_TICKS_RESET;
      rdata_ff <= 32'h0;
    end else begin
      wait_ff <= ~(bus_req & wait_ff);
      if (bus_take && i_avs_write) begin
        if (i_avs_address == CST_REG_CTRL) begin
          ctrl_ff <= i_avs_writedata[2:0];
        end
        if (i_avs_address == CST_REG_TMR_LIMIT) begin
          fast_limit_ff <= i_avs_writedata;
        end
      end
      if (bus_take && i_avs_read) begin
        case (i_avs_address)
          CST_REG_CTRL: rdata_ff <= {29'h0, ctrl_ff};
          CST_REG_STATUS: rdata_ff <= {16'h0, cur_ff, 1'b0, fault_ff, tshut_ff,
                                       2'(phase_ff), mode_ff};
          CST_REG_TMR_LIMIT: rdata_ff <= fast_limit_ff;
          CST_REG_TMR_COUNT: rdata_ff <= pre_cnt_ff;
          default: rdata_ff <= 32'h0;
        endcase
      end
    end
  end

  assign o_avs_waitrequest = wait_ff;
  assign o_avs_readdata = rdata_ff;
  assign o_power_stage_on = stage_ff;
  assign o_fast_current_sel = fast_ff;
  assign o_prechg_current_sel = pre_ff;
  assign o_cv_phase = cv_ff;
  assign o_recovery_trickle_on = trickle_ff;
  assign o_current_limit = cur_ff;
  assign o_status_out_a_pd = stat_a_ff;
  assign o_status_out_b_pd = stat_b_ff;
  assign o_power_good_n_pd = pg_ff;

  a_pg_follows: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    $rose(cmp.in_present & ~cmp.in_overvolt) |=> o_power_good_n_pd) else $error("pg late");
  // no input means stage off soon
  a_sleep_off: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !cmp.in_present |-> ##2 !o_power_stage_on) else $error("stage on in sleep");
  a_fault_cause: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    $rose(fault_ff) |-> $past(pre_expired)) else $error("fault without timeout");
  // input loss clears fault; a set in the first cycle still wins
  a_fault_clear: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !cmp.in_present ##1 !cmp.in_present |=> !fault_ff) else $error("fault not cleared");
  a_stby_reset: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    mode_ff == CST_STANDBY |=> pre_cnt_ff == 32'h0) else $error("timer not reset");
  a_susp_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    mode_ff == CST_SUSPEND && !cmp.above_prechg && !tmr_open |=> $stable(pre_cnt_ff))
    else $error("timer moved in suspend");
  // no done code when termination off
  a_no_done: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    term_disabled |=> !(!o_status_out_a_pd && o_status_out_b_pd)) else $error("done shown");
  a_cur_floor: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_current_limit >= CST_CUR_FLOOR) else $error("current under floor");
  a_ovp_standby: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    cmp.in_present && cmp.in_overvolt |=> mode_ff == CST_STANDBY) else $error("no standby");
  a_ovp_release: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    $fell(cmp.in_overvolt) && cmp.in_present && !ce_n_ff |=> mode_ff != CST_STANDBY)
    else $error("overvoltage latched");
  a_pg_ovp: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    cmp.in_overvolt |=> !o_power_good_n_pd) else $error("pg low in overvoltage");
  a_pg_absent: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !cmp.in_present |=> !o_power_good_n_pd) else $error("pg low without input");
  a_tshut_stage: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    tshut_ff |-> ##2 !o_power_stage_on) else $error("stage on in shutdown");
  // pack temperature out stops the stage
  a_temp_off: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !cmp.temp_ok |-> ##2 !o_power_stage_on) else $error("stage on out of window");
  // both status pins off outside charging
  a_stat_off: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    mode_ff != CST_CHARGING |=> !o_status_out_a_pd && !o_status_out_b_pd)
    else $error("status shown while off");
  a_trickle_cause: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_recovery_trickle_on |-> $past(fault_ff)) else $error("trickle without fault");
  a_cnt_above: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    cmp.above_prechg |=> pre_cnt_ff == 32'h0) else $error("count kept above threshold");
  // enable rise clears fault outside charging
  a_ce_clear: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    ce_rise && mode_ff != CST_CHARGING |=> !fault_ff) else $error("fault kept on enable");
  a_pre_sel: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    charging && phase_ff == CST_PH_PRECHG |=> o_prechg_current_sel && !o_fast_current_sel)
    else $error("wrong current select");
  a_cv_phase: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    cmp.at_reg |=> phase_ff == CST_PH_CV) else $error("no voltage phase");
  a_sleep_mode: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !cmp.in_present |=> mode_ff == CST_SLEEP) else $error("no sleep");
endmodule : cst_top

// ===== sim/cst_pack_model.sv
// Battery pack and pulled-up status pins seen from the charger
`timescale 1ns/1ps
module cst_pack_model (
  input wire logic i_clk_sys,
  input wire logic i_charge,
  input wire logic i_dead,
  input wire logic i_pd_a,
  input wire logic i_pd_b,
  input wire logic i_pd_pg,
  output logic o_above_prechg,
  output logic o_at_reg,
  output logic o_pin_a,
  output logic o_pin_b,
  output logic o_pin_pg
);
  logic [7:0] volt_ff = 8'h00;
  // Cell rises while current flows; a dead cell stays flat
  always @(posedge i_clk_sys) begin
    if (i_charge && !i_dead && volt_ff != 8'hff) begin
      volt_ff <= volt_ff + 8'h01;
    end
  end
  // Thresholds in model units, far apart so phases stay visible
  assign o_above_prechg = volt_ff > 8'h28;
  assign o_at_reg = volt_ff > 8'h78;
  // pull-up resistors: a released pin reads high
  assign o_pin_a = ~i_pd_a;
  assign o_pin_b = ~i_pd_b;
  assign o_pin_pg = ~i_pd_pg;
endmodule : cst_pack_model

// ===== sim/charge_status_timer_control_test.sv
// Testbench for the charge status and timer control block
`timescale 1ns/1ps
`define CHK(s, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected %s exp %h got %h", s, e, g); end end
`define WAITQ(c, l) begin for (n = 0; n < l && (c) !== 1'b1; n++) @(posedge clk_sys); \
  if ((c) !== 1'b1) begin fail_count++; final_report(); end end
module charge_status_timer_control_test;
  import cst_pkg::*;
  // Tick length, and precharge ticks for the fast limit of 1 written below
  localparam int TICK_LEN = int'(CST_TICK_DIV) + 1;
  localparam int PRE_TICKS = 1 << CST_PRECHG_FACTOR_SHIFT;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic en_n = 1'b1;
  logic dead = 1'b0;
  cst_cmp_s cmp_tb = '0;
  cst_cmp_s cmp;
  logic [3:0] addr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, d, c1, c2;
  logic [31:0] avs_rdata;
  logic wait_req, stage_on, fast_sel, pre_sel, cv, trickle;
  logic [7:0] cur_lim;
  logic pd_a, pd_b, pd_pg, above, at_reg, pin_a, pin_b, pin_pg;
  int fail_count = 0;
  int compares = 0;
  int n;
  // Battery-driven comparators come from the pack model
  always_comb begin
    cmp = cmp_tb;
    cmp.above_prechg = above;
    cmp.at_reg = at_reg;
  end
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  cst_top cst_top_inst (.i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_charge_enable_n(en_n),
    .i_cmp(cmp), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdata), .o_avs_readdata(avs_rdata), .o_avs_waitrequest(wait_req),
    .o_power_stage_on(stage_on), .o_fast_current_sel(fast_sel),
    .o_prechg_current_sel(pre_sel), .o_cv_phase(cv), .o_recovery_trickle_on(trickle),
    .o_current_limit(cur_lim), .o_status_out_a_pd(pd_a), .o_status_out_b_pd(pd_b),
    .o_power_good_n_pd(pd_pg));
  cst_pack_model cst_pack_model_inst (.i_clk_sys(clk_sys), .i_charge(stage_on | trickle),
    .i_dead(dead), .i_pd_a(pd_a), .i_pd_b(pd_b), .i_pd_pg(pd_pg),
    .o_above_prechg(above), .o_at_reg(at_reg), .o_pin_a(pin_a), .o_pin_b(pin_b),
    .o_pin_pg(pin_pg));
  task automatic final_report();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report
  // One bus cycle, held until waitrequest is seen low
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge clk_sys);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= wd;
    do begin
      @(posedge clk_sys);
      k++;
    end while (wait_req !== 1'b0 && k < 50);
    if (k >= 50) begin
      fail_count++;
      final_report();
    end
    rdata = avs_rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : xfer
  // Comparator edges need sync plus mode and output stages
  task automatic settle();
    repeat (8) @(posedge clk_sys);
  endtask : settle
  task automatic pins(input logic [2:0] e);
    `CHK("pins", e, {pin_a, pin_b, pin_pg})
  endtask : pins
  task automatic tend(input string s);
    $display("test %s done", s);
  endtask : tend
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    `CHK("limit rst", 8'hff, cur_lim)
    xfer(1'b0, CST_REG_CTRL, 32'h0);
    `CHK("ctrl rst", 32'h0, rdata)
    xfer(1'b0, CST_REG_TMR_LIMIT, 32'h0);
    `CHK("tlim rst", CST_FAST_TIMEOUT_TICKS_RESET, rdata)
    xfer(1'b0, 4'h1, 32'h0);
    `CHK("unmapped", 32'h0, rdata)
    xfer(1'b1, CST_REG_CTRL, 32'h7);
    xfer(1'b0, CST_REG_CTRL, 32'h0);
    `CHK("ctrl rw", 3'h7, rdata[2:0])
    xfer(1'b1, CST_REG_CTRL, 32'h0);
    xfer(1'b1, CST_REG_TMR_LIMIT, 32'h1);
    pins(3'b111);
    tend("reset");
    cmp_tb.in_present <= 1'b1;
    cmp_tb.temp_ok <= 1'b1;
    dead <= 1'b1;
    settle();
    pins(3'b110);
    xfer(1'b0, CST_REG_STATUS, 32'h0);
    `CHK("standby", 3'h1, rdata[2:0])
    en_n <= 1'b0;
    settle();
    `CHK("pre sel", 2'b11, {stage_on, pre_sel})
    pins(3'b000);
    repeat (300) @(posedge clk_sys);
    cmp_tb.temp_ok <= 1'b0;
    settle();
    `CHK("suspend", 1'b0, stage_on)
    pins(3'b110);
    xfer(1'b0, CST_REG_TMR_COUNT, 32'h0);
    c1 = rdata;
    repeat (300) @(posedge clk_sys);
    xfer(1'b0, CST_REG_TMR_COUNT, 32'h0);
    `CHK("hold", c1, rdata)
    `CHK("held", 1'b1, c1 != 0)
    cmp_tb.temp_ok <= 1'b1;
    settle();
    `CHK("resume", 1'b1, stage_on)
    `WAITQ(stage_on === 1'b0, 1200)
    // Remaining ticks after the held count, tick phase unknown, few cycles of latency
    d = (PRE_TICKS - c1) * TICK_LEN;
    `CHK("fault at", 1'b1, n + 8 > d - TICK_LEN && n < d + 8)
    xfer(1'b0, CST_REG_STATUS, 32'h0);
    `CHK("latch", 1'b1, rdata[6])
    `CHK("trickle", 1'b1, trickle)
    pins(3'b110);
    en_n <= 1'b1;
    settle();
    xfer(1'b0, CST_REG_STATUS, 32'h0);
    `CHK("clr", 2'b00, {rdata[6], trickle})
    xfer(1'b0, CST_REG_TMR_COUNT, 32'h0);
    `CHK("rst cnt", 32'h0, rdata)
    tend("precharge");
    dead <= 1'b0;
    en_n <= 1'b0;
    `WAITQ(fast_sel, 200)
    settle();
    pins(3'b010);
    `WAITQ(cv, 400)
    xfer(1'b1, CST_REG_CTRL, 32'h4);
    settle();
    pins(3'b100);
    xfer(1'b1, CST_REG_CTRL, 32'h6);
    settle();
    pins(3'b010);
    tend("fast");
    cmp_tb.in_overvolt <= 1'b1;
    settle();
    `CHK("ovp off", 1'b0, stage_on)
    pins(3'b111);
    xfer(1'b0, CST_REG_STATUS, 32'h0);
    `CHK("ovp mode", 3'h1, rdata[2:0])
    cmp_tb.in_overvolt <= 1'b0;
    settle();
    `CHK("ovp back", 1'b1, stage_on)
    cmp_tb.tj_over_reg <= 1'b1;
    repeat (400) @(posedge clk_sys);
    `CHK("fold", 1'b1, cur_lim < CST_CUR_FULL && cur_lim >= CST_CUR_FLOOR)
    cmp_tb.tj_shutdown <= 1'b1;
    settle();
    `CHK("tshut", 1'b0, stage_on)
    cmp_tb.tj_shutdown <= 1'b0;
    cmp_tb.tj_over_reg <= 1'b0;
    cmp_tb.in_present <= 1'b0;
    settle();
    `CHK("sleep", 1'b0, stage_on)
    pins(3'b111);
    tend("protect");
    final_report();
  end
endmodule : charge_status_timer_control_test
